/* counter_mode_sequencer.sv */
// one counter channel sequencing rate, one-shot, delayed-pulse and duty modes
`timescale 1ns/100ps
`include "cnt_seq_defines.svh"

// Contract
// - ungated rate mode repeats, reloads load
// - toggled output inverts each terminal count
// - level-gated rate counts while gate active
// - one-shot starts on gate edge, no rearm
// - one-shot ignores gate until terminal count
// - delayed pulse: hold reload, then load, disarm
// - load command copies load register
// - level-gated delayed pulse stretches both phases
// - hw delayed pulse ignores edges when disarmed
// - hw delayed pulse ignores gate till second
// - duty mode alternates hold then load
// - duty mode runs until disarm command
// - level-gated duty mode alternates, gate stretches
// - hw duty: second terminal count stops, awaits edge
// - edge-disarm strobe disarms, freezes count
// - edge-disarm one-shot disarms, freezes count
// - edge-disarm delayed pulse disarms, freezes count
// - edge-disarm duty mode disarms, freezes count
// - terminal-count state always counts out
// - mode from special, reload, repeat, gate bits
// - non-special codes equal basic modes
module counter_mode_sequencer
  import cnt_seq_pkg::*;
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_arst_n,
  input  wire logic                  i_source,            // external source pin
  input  wire logic                  i_gate,              // external gate pin, high active
  input  wire logic                  i_special_gate_bit,  // edge-disarm variant
  input  wire logic                  i_reload_select_bit, // 1: alternate load/hold
  input  wire logic                  i_repeat_bit,        // 1: repeat
  input  wire logic [3:0]            i_gate_control_field,
  input  wire logic [`CNT_WIDTH-1:0] i_load_value,        // load register
  input  wire logic [`CNT_WIDTH-1:0] i_hold_value,        // hold register
  input  wire logic                  i_arm_cmd,           // one-cycle pulse
  input  wire logic                  i_disarm_cmd,        // one-cycle pulse
  input  wire logic                  i_load_cmd,          // one-cycle pulse
  input  wire logic                  i_clear_count_cmd,   // one-cycle pulse
  output logic [`CNT_WIDTH-1:0]      o_count,
  output logic                       o_terminal_count,    // pulse output
  output logic                       o_tc_toggle,         // toggled output
  output logic                       o_armed
);

  //////////////////////////////////////////////////////////////////////////
  // input conditioning
  edge_sync_if sync ();

  edge_sync u_edge_sync (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_source   (i_source),
    .i_gate     (i_gate),
    .sync       (sync.producer)
  );

  //////////////////////////////////////////////////////////////////////////
  // mode decode
  gating_e gating;       // decoded gate control
  logic    triggered;    // gate edge seen in edge modes
  logic    hold_phase;   // next reload comes from hold
  logic    in_tc;        // counter sits in terminal-count state
  logic    qualified;    // this source edge is counted
  logic    at_end;       // this counted edge reaches terminal count
  logic    edge_disarm;  // special variant active on an edge mode

  // unmapped gate codes fall back to no gating
  function automatic gating_e decode_gating(input logic [3:0] f);
    if (f == `GATE_LEVEL) begin
      return GATING_LEVEL;
    end else if (f == `GATE_EDGE) begin
      return GATING_EDGE;
    end
    return GATING_NONE;
  endfunction

  // special bit only changes edge-gated codes
  always_comb begin
    gating      = decode_gating(i_gate_control_field);
    edge_disarm = i_special_gate_bit && (gating == GATING_EDGE);
  end

  // counting qualification
  always_comb begin
    unique case (gating)
      GATING_NONE:  qualified = sync.src_rise && o_armed;
      GATING_LEVEL: qualified = sync.src_rise && o_armed && sync.gate_lvl;
      GATING_EDGE:  qualified = sync.src_rise && o_armed && triggered;
    endcase
    // terminal-count state is always driven out by the next edge
    if (in_tc && sync.src_rise) begin
      qualified = 1'b1;
    end
    at_end = qualified && (o_count == `CNT_WIDTH'(1));
  end

  //////////////////////////////////////////////////////////////////////////
  // counter register; reload happens on the edge leaving terminal count
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_count <= `CNT_RESET_VALUE;
    end else if (i_clear_count_cmd) begin
      o_count <= `CNT_RESET_VALUE;
    end else if (i_load_cmd) begin
      o_count <= i_load_value;
    end else if (qualified) begin
      if (in_tc) begin
        // hold first, then load, so initial count sets delay
        o_count <= (i_reload_select_bit && hold_phase) ? i_hold_value : i_load_value;
      end else begin
        o_count <= o_count - `CNT_WIDTH'(1);
      end
    end
  end

  // terminal-count state and outputs
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      in_tc            <= 1'b0;
      o_terminal_count <= 1'b0;
      o_tc_toggle      <= 1'b0;
    end else begin
      if (i_load_cmd || i_clear_count_cmd) begin
        in_tc            <= 1'b0;
        o_terminal_count <= 1'b0;
      end else if (at_end) begin
        in_tc            <= 1'b1;
        o_terminal_count <= 1'b1;
        o_tc_toggle      <= !o_tc_toggle;
      end else if (in_tc && qualified) begin
        in_tc            <= 1'b0;
        o_terminal_count <= 1'b0;
      end
    end
  end

  // reload-source alternation, reset by load so cycles start on hold
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hold_phase <= 1'b1;
    end else if (i_load_cmd || i_clear_count_cmd) begin
      hold_phase <= 1'b1;
    end else if (in_tc && qualified) begin
      hold_phase <= !hold_phase;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // edge trigger latch; edges on a disarmed counter are dropped
  logic cycle_done;  // leaving terminal count on a load reload ends a trigger cycle
  always_comb begin
    cycle_done = in_tc && qualified && (!i_reload_select_bit || !hold_phase);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      triggered <= 1'b0;
    end else if (!o_armed || i_disarm_cmd) begin
      triggered <= 1'b0;
    end else if (edge_disarm && sync.gate_fall) begin
      triggered <= 1'b0;
    end else if (cycle_done) begin
      triggered <= 1'b0;
    end else if (sync.gate_rise && gating == GATING_EDGE) begin
      triggered <= 1'b1;
    end
  end

  // arming: repeat modes keep arm, others disarm at the cycle end
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_armed <= 1'b0;
    end else if (i_disarm_cmd) begin
      o_armed <= 1'b0;
    end else if (edge_disarm && sync.gate_fall) begin
      o_armed <= 1'b0;
    end else if (cycle_done && !i_repeat_bit) begin
      o_armed <= 1'b0;
    end else if (i_arm_cmd) begin
      o_armed <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  sequence tc_enter_s;
    at_end ##1 o_terminal_count;
  endsequence

  // terminal count raised on the same edge as the last decrement
  tc_pulse_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    at_end && !i_load_cmd && !i_clear_count_cmd |-> tc_enter_s)
    else $error("terminal count not raised");

  // toggled output flips once per terminal count
  toggle_flip_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    at_end && !i_load_cmd && !i_clear_count_cmd |=> o_tc_toggle != $past(o_tc_toggle))
    else $error("toggle output did not invert");

  // toggled output moves only on entry to terminal count
  toggle_steady_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !at_end |=> $stable(o_tc_toggle))
    else $error("toggle output moved outside terminal count");

  // load command copies the load register
  load_cmd_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_load_cmd && !i_clear_count_cmd |=> o_count == $past(i_load_value))
    else $error("load command did not load");

  // clear command empties the counter
  clear_cmd_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_clear_count_cmd |=> o_count == `CNT_RESET_VALUE)
    else $error("clear did not zero count");

  // terminal-count state ends on the next source edge
  tc_exit_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    in_tc && sync.src_rise && !i_load_cmd && !i_clear_count_cmd |=> !o_terminal_count)
    else $error("terminal count not left");

  // pulse output only stands while the count is empty
  tc_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_terminal_count |-> o_count == '0)
    else $error("terminal count with nonzero count");

  // inactive-going gate edge drops the arm in special modes
  edge_disarm_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    edge_disarm && sync.gate_fall |=> !o_armed)
    else $error("edge disarm missed");

  // level gating freezes the count while the gate is low
  level_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    gating == GATING_LEVEL && !sync.gate_lvl && !in_tc && !i_load_cmd
      && !i_clear_count_cmd |=> $stable(o_count))
    else $error("count moved with gate inactive");

  // disarm command always wins
  disarm_cmd_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_disarm_cmd |=> !o_armed)
    else $error("disarm command ignored");

  // only an arm command can arm; gate edges never do
  stay_disarmed_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !o_armed && !i_arm_cmd |=> !o_armed)
    else $error("armed without command");

  // arm command takes effect when nothing outranks it
  arm_cmd_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_arm_cmd && !i_disarm_cmd && !(edge_disarm && sync.gate_fall)
      && !(cycle_done && !i_repeat_bit) |=> o_armed)
    else $error("arm command ignored");

  // single-cycle modes disarm at the end of their cycle
  cycle_disarm_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    cycle_done && !i_repeat_bit |=> !o_armed)
    else $error("cycle end did not disarm");

  // repeating modes stay armed until told otherwise
  repeat_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_armed && i_repeat_bit && !i_disarm_cmd
      && !(edge_disarm && sync.gate_fall) |=> o_armed)
    else $error("repeating counter disarmed itself");

  // a disarmed counter holds its value outside terminal count
  disarmed_freeze_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !o_armed && !in_tc && !i_load_cmd
      && !i_clear_count_cmd |=> $stable(o_count))
    else $error("disarmed count moved");

  // ungated armed counter steps down by one per source edge
  ungated_step_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    gating == GATING_NONE && o_armed && sync.src_rise && !in_tc && !i_load_cmd
      && !i_clear_count_cmd |=> o_count == $past(o_count) - `CNT_WIDTH'(1))
    else $error("count did not step down");

  // first reload of a pair comes from hold
  reload_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    in_tc && qualified && i_reload_select_bit && hold_phase && !i_load_cmd
      && !i_clear_count_cmd |=> o_count == $past(i_hold_value))
    else $error("hold reload missed");

  // every other reload comes from load
  reload_load_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    in_tc && qualified && !(i_reload_select_bit && hold_phase) && !i_load_cmd
      && !i_clear_count_cmd |=> o_count == $past(i_load_value))
    else $error("load reload missed");

  // edge modes do not count before their trigger
  wait_trigger_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    gating == GATING_EDGE && !triggered && !in_tc && !i_load_cmd
      && !i_clear_count_cmd |=> $stable(o_count))
    else $error("edge mode counted untriggered");

  // once triggered, gate moves are ignored until the cycle ends
  trig_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    gating == GATING_EDGE && triggered && o_armed && !cycle_done
      && !i_disarm_cmd && !edge_disarm |=> triggered)
    else $error("trigger lost mid cycle");

  // load-only edge modes stop after one terminal count
  oneshot_stop_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    in_tc && sync.src_rise && gating == GATING_EDGE && !i_reload_select_bit
      && !i_load_cmd && !i_clear_count_cmd |=> !triggered)
    else $error("one-shot kept counting");

  // alternating edge modes stop after the load reload
  pair_stop_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    in_tc && sync.src_rise && gating == GATING_EDGE && !hold_phase
      && !i_load_cmd && !i_clear_count_cmd |=> !triggered)
    else $error("pair cycle kept counting");
endmodule

/* cnt_seq_defines.svh */
// constants for the counter mode sequencer
`ifndef CNT_SEQ_DEFINES_SVH
`define CNT_SEQ_DEFINES_SVH
`define CNT_WIDTH        16
`define CNT_RESET_VALUE  16'h0000
`define GATE_NONE        4'h0
`define GATE_LEVEL       4'h1
`define GATE_EDGE        4'h2
`endif

/* cnt_seq_pkg.sv */
// types shared by the counter mode sequencer
`include "cnt_seq_defines.svh"
package cnt_seq_pkg;
  typedef logic [`CNT_WIDTH-1:0] count_t;   // counter word
  typedef enum logic [1:0] {
    GATING_NONE,
    GATING_LEVEL,
    GATING_EDGE
  } gating_e;
endpackage

/* edge_sync_if.sv */
// carrier for synchronised input levels and edges
`timescale 1ns/100ps
interface edge_sync_if;
  logic src_rise;   // qualified source edge
  logic gate_lvl;   // synchronised gate level
  logic gate_rise;  // gate going active
  logic gate_fall;  // gate going inactive
  modport producer (output src_rise, gate_lvl, gate_rise, gate_fall);
  modport consumer (input src_rise, gate_lvl, gate_rise, gate_fall);
endinterface

/* edge_sync.sv */
// three-stage synchroniser and edge detector for source and gate
`timescale 1ns/100ps
module edge_sync (
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  input  wire logic i_source,
  input  wire logic i_gate,
  edge_sync_if.producer sync
);
  logic [2:0] src_sr;   // source shift chain
  logic [2:0] gate_sr;  // gate shift chain
  logic       src_q;    // agreed source level
  logic       gate_q;   // agreed gate level

  //////////////////////////////////////////////////////////////////////////
  // sampling chains; stage 0 is read only by stage 1
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      src_sr  <= 3'h0;
      gate_sr <= 3'h0;
    end else begin
      src_sr  <= {src_sr[1:0], i_source};
      gate_sr <= {gate_sr[1:0], i_gate};
    end
  end

  // a change counts only when stages two and three agree
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      src_q  <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      if (src_sr[1] == src_sr[2]) begin
        src_q <= src_sr[2];
      end
      if (gate_sr[1] == gate_sr[2]) begin
        gate_q <= gate_sr[2];
      end
    end
  end

  // edges from the agreed levels, one pulse each
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync.src_rise  <= 1'b0;
      sync.gate_lvl  <= 1'b0;
      sync.gate_rise <= 1'b0;
      sync.gate_fall <= 1'b0;
    end else begin
      sync.src_rise  <= (src_sr[1] == src_sr[2]) && src_sr[2] && !src_q;
      sync.gate_lvl  <= gate_q;
      sync.gate_rise <= (gate_sr[1] == gate_sr[2]) && gate_sr[2] && !gate_q;
      sync.gate_fall <= (gate_sr[1] == gate_sr[2]) && !gate_sr[2] && gate_q;
    end
  end
endmodule

/* src_gate_drv.sv */
// far-side model: external source pulses and gate level for the sequencer
`timescale 1ns/100ps
module src_gate_drv (
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  input  wire logic i_pulse_req,  // one-cycle request for one source pulse
  input  wire logic i_gate_req,   // wanted gate level
  output logic      o_source,     // source pin
  output logic      o_gate,       // gate pin
  output logic      o_done        // pulse finished, one cycle
);
  logic [3:0] phase;  // pulse progress, 0 when idle

  ////////////////////////////////////////////////////////////////////////////////
  // four cycles high then four low: above the two the synchroniser needs
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase <= 4'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= (phase == 4'h8);
      if (phase == 4'h8) begin  // pulse complete
        phase <= 4'h0;
      end else if (phase != 4'h0 || i_pulse_req) begin
        phase <= phase + 4'h1;
      end
    end
  end
  assign o_source = (phase != 4'h0) && (phase <= 4'h4);

  ////////////////////////////////////////////////////////////////////////////////
  // gate follows the bench request one cycle later
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_gate <= 1'b0;
    end else begin
      o_gate <= i_gate_req;
    end
  end
endmodule

/* counter_mode_sequencer_tb.sv */
// self-checking bench for the counter mode sequencer with a reference model
`timescale 1ns/100ps
module counter_mode_sequencer_tb;
  import cnt_seq_pkg::*;
  logic        i_core_clk, i_arst_n;   // clock and reset
  logic        sp, rs, rep;            // mode bits
  logic [3:0]  gc;                     // gate control field
  count_t      ld, hd;                 // load and hold values
  logic [3:0]  cmd_v;                  // {clear, load, disarm, arm}
  logic        pulse_req, gate_req;    // requests to the far-side model
  logic        src, gate, done;        // far-side pins
  count_t      o_count;                // design outputs
  logic        o_tc, o_tog, o_armed;
  logic [31:0] rng;                    // xorshift state
  int          mismatches, n_tests, cycles;
  int          m_count, m_tc, m_tog, m_armed, m_phase, m_trig;  // reference state

  counter_mode_sequencer counter_mode_sequencer_inst (.i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n), .i_source(src), .i_gate(gate), .i_special_gate_bit(sp),
    .i_reload_select_bit(rs), .i_repeat_bit(rep), .i_gate_control_field(gc),
    .i_load_value(ld), .i_hold_value(hd), .i_arm_cmd(cmd_v[0]), .i_disarm_cmd(cmd_v[1]),
    .i_load_cmd(cmd_v[2]), .i_clear_count_cmd(cmd_v[3]), .o_count(o_count),
    .o_terminal_count(o_tc), .o_tc_toggle(o_tog), .o_armed(o_armed));
  src_gate_drv src_gate_drv_inst (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_pulse_req(pulse_req), .i_gate_req(gate_req), .o_source(src), .o_gate(gate),
    .o_done(done));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; about 8k cycles expected
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  initial begin
    cycles = 0;
    forever @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 60000) begin
        mismatches++;
        $display("Error at %0t: run timed out", $time);
        end_sim();
      end
    end
  end

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // compare all outputs with the reference
  task automatic chk(input string what);
    n_tests++;
    if (o_count !== count_t'(m_count) || o_tc !== 1'(m_tc) || o_tog !== 1'(m_tog)
        || o_armed !== 1'(m_armed)) begin
      mismatches++;
      $display("Error at %0t: %s count %h want %h tc %b tog %b armed %b", $time, what,
               o_count, m_count[15:0], o_tc, o_tog, o_armed);
    end
  endtask

  // reset held 8 cycles, mode picked while held, pins settle after release
  task automatic do_reset(input int m);
    logic [31:0] r;
    r = xs();
    @(posedge i_core_clk) i_arst_n <= 1'b0;
    gate_req <= 1'b0;
    sp <= (m >= 12);
    gc <= (m < 12) ? 4'(m % 3) : (m < 16) ? 4'h2 : (m == 18) ? 4'h9 : 4'(m - 16);
    rs <= (m < 12) ? 1'(m / 6) : (m < 16) ? 1'((m - 12) / 2) : 1'b0;
    rep <= (m < 12) ? 1'((m / 3) % 2) : (m < 16) ? 1'((m - 12) % 2) : 1'b0;
    ld <= 16'h0001 + count_t'(r[1:0]);
    hd <= 16'h0001 + count_t'(r[4:3]);
    repeat (8) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    {m_count, m_tc, m_tog, m_armed, m_phase, m_trig} = '0;
    repeat (6) @(posedge i_core_clk);
    chk("reset");
  endtask

  // one-cycle command pulse: 0 arm, 1 disarm, 2 load, 3 clear
  task automatic cmd(input int k);
    @(posedge i_core_clk) cmd_v <= 4'(1 << k);
    @(posedge i_core_clk) cmd_v <= 4'h0;
    case (k)
      0: m_armed = 1;
      1: begin
        m_armed = 0;
        m_trig = 0;
      end
      default: begin
        m_count = (k == 2) ? int'(ld) : 0;  // load copies load value, clear zeroes
        m_tc = 0;
        m_phase = 0;
      end
    endcase
    repeat (2) @(posedge i_core_clk);
    chk("command");
  endtask

  // gate change, kept out of the terminal-count state
  task automatic set_gate(input logic v);
    if (m_tc == 0) begin
      @(posedge i_core_clk) gate_req <= v;
      repeat (8) @(posedge i_core_clk);
      if (v && m_armed != 0 && gc == 4'h2) m_trig = 1;
      if (!v && sp && gc == 4'h2 && m_armed != 0) begin
        m_armed = 0;
        m_trig = 0;
      end
    end
  endtask

  // one source pulse through the far-side model, then the reference step
  task automatic pulse();
    int w;
    @(posedge i_core_clk) pulse_req <= 1'b1;
    @(posedge i_core_clk) pulse_req <= 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 20) begin
      @(posedge i_core_clk);
      w++;
    end
    if (m_tc != 0) begin  // terminal count always counts out
      m_tc = 0;
      if (rs && m_phase == 0) begin
        m_count = int'(hd);
        m_phase = 1;
      end else begin
        m_count = int'(ld);
        m_phase = 0;
        if (!rep) m_armed = 0;
        if (gc == 4'h2) m_trig = 0;
      end
    end else if (m_armed != 0 && (gc == 4'h1 ? gate_req : gc == 4'h2 ? m_trig != 0 : 1'b1)) begin
      m_count = m_count - 1;
      if (m_count == 0) begin
        m_tc = 1;
        m_tog = 1 - m_tog;
      end
    end
    repeat (2) @(posedge i_core_clk);
    chk("source edge");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // every mode: load, arm, then random gate moves and re-arms between pulses
  initial begin
    logic [31:0] r;
    i_arst_n = 1'b0;
    {sp, rs, rep, gc, ld, hd, cmd_v, pulse_req, gate_req} = '0;
    mismatches = 0;
    n_tests = 0;
    rng = 32'h0001_3620;
    for (int m = 0; m < 19; m++) begin
      do_reset(m);
      cmd(2);
      cmd(0);
      for (int s = 0; s < 24; s++) begin
        r = xs();
        if (r[2:0] == 3'h0 && m_armed == 0) cmd(0);
        else if (r[2:0] < 3'h4) set_gate(~gate_req);
        pulse();
      end
      cmd(1);
      cmd(3);
    end
    end_sim();
  end
endmodule
